// [design/slwcr_regs.vh]
`ifndef SLWCR_REGS_VH
`define SLWCR_REGS_VH

// Register offsets
`define SLWCR_OFS_IO_CONTROL 11'h461
`define SLWCR_OFS_STRAP_ONE 11'h467
`define SLWCR_OFS_STRAP_TWO 11'h468
`define SLWCR_OFS_LED_CTRL 11'h469
`define SLWCR_OFS_WAKE_CFG 11'h4A0

// Reset values
`define SLWCR_RST_IO_CONTROL 16'h0000
`define SLWCR_RST_STRAP_ONE 16'h0101
`define SLWCR_RST_STRAP_TWO 16'h0080
`define SLWCR_RST_LED_CTRL 16'h0040
`define SLWCR_RST_WAKE_CFG 16'h1081

// Writable bit masks
`define SLWCR_MASK_LED_CTRL 16'h0077
`define SLWCR_MASK_WAKE_CFG 16'h17E1

// Strap readback one fields
`define SLWCR_B_ADDR1 13
`define SLWCR_B_ADDR0 12
`define SLWCR_B_XOVER 8
`define SLWCR_B_RMII_ROLE 3
`define SLWCR_B_AUTONEG 0

// Strap readback two fields
`define SLWCR_B_LINK_POL 7

// LED control fields
`define SLWCR_B_LED2_POL 6
`define SLWCR_B_LED2_VAL 5
`define SLWCR_B_LED2_EN 4
`define SLWCR_B_LED1_POL 2
`define SLWCR_B_LED1_VAL 1
`define SLWCR_B_LED1_EN 0

// Wake filter config fields
`define SLWCR_B_CRC_GATE 12
`define SLWCR_B_WAKE_CLR 11
`define SLWCR_B_PULSE_HI 10
`define SLWCR_B_PULSE_LO 9
`define SLWCR_B_WAKE_STYLE 8
`define SLWCR_B_WAKE_EN 7

// Pulse widths in clock cycles
`define SLWCR_PULSE_W0 7'h08
`define SLWCR_PULSE_W1 7'h10
`define SLWCR_PULSE_W2 7'h20
`define SLWCR_PULSE_W3 7'h40

// Cycles after reset release before straps are latched
`define SLWCR_STRAP_SETTLE 2'h3

`endif

// [design/slwcr_wake_ind.v]
`include "slwcr_regs.vh"
`default_nettype none

module slwcr_wake_ind (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // Control
  input wire event_i,
  input wire style_i,
  input wire [1:0] width_sel_i,
  input wire clear_i,
  // Indication
  output wire ind_o
);

  reg ind_ff;
  reg nxt_ind;
  reg [6:0] cnt_ff;
  reg [6:0] nxt_cnt;
  reg [6:0] width;

  always @* begin
    case (width_sel_i)
      2'b00: width = `SLWCR_PULSE_W0;
      2'b01: width = `SLWCR_PULSE_W1;
      2'b10: width = `SLWCR_PULSE_W2;
      default: width = `SLWCR_PULSE_W3;
    endcase
  end

  always @* begin
    nxt_ind = ind_ff;
    nxt_cnt = cnt_ff;
    if (style_i) begin
      // Level held until cleared, new event wins over clear
      nxt_cnt = 7'h00;
      if (event_i) begin
        nxt_ind = 1'b1; // [RULE11]
      end else if (clear_i) begin
        nxt_ind = 1'b0; // [RULE10]
      end
    end else begin
      // Fixed-width pulse, retriggered by a new event
      if (event_i) begin
        nxt_ind = 1'b1; // [RULE11]
        nxt_cnt = width - 7'h01;
      end else if (cnt_ff != 7'h00) begin
        nxt_cnt = cnt_ff - 7'h01;
      end else begin
        nxt_ind = 1'b0;
      end
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ind_ff <= 1'b0;
      cnt_ff <= 7'h00;
    end else begin
      ind_ff <= nxt_ind;
      cnt_ff <= nxt_cnt;
    end
  end

  assign ind_o = ind_ff;

endmodule // slwcr_wake_ind

`default_nettype wire

// [design/slwcr_top.v]
`include "slwcr_regs.vh"
`default_nettype none

// Overview of operation
// RULE1: Strap address bits 1 and 0 read back in bits 13 and 12.
// RULE2: Bit 8 shows latched crossover strap, one is automatic; resets to one.
// RULE3: Bit 3 shows latched RMII role, zero master 25MHz, one slave 50MHz.
// RULE4: Bit 0 shows latched auto-negotiation strap; resets to one.
// RULE5: Second readback bit 7 shows link lamp polarity, one active high.
// RULE6: LED control bit 6 holds second LED polarity; resets to one.
// RULE7: LED control bit 2 holds first LED polarity, strap loaded, reset zero.
// RULE8: Drive-enable bits force LED from drive-value bits through polarity.
// RULE9: CRC gate bit 12 suppresses indications of bad-CRC wake packets.
// RULE10: Writing bit 11 clears wake level; write-only, self-clearing.
// RULE11: Bit 8 selects wake indication as pulse or held level.
// RULE12: Reserved bits read zero, ignore writes; io control reads zero.
module slwcr_top (
  // Clock and reset
  input wire sys_clk_i,
  input wire rstn_i,
  // Strap pins
  input wire strap_addr_bit1_i,
  input wire strap_addr_bit0_i,
  input wire strap_auto_crossover_i,
  input wire strap_rmii_role_i,
  input wire strap_autoneg_i,
  input wire strap_link_lamp_polarity_i,
  input wire strap_led1_polarity_i,
  // Management register port
  input wire [10:0] mgmt_addr_i,
  input wire mgmt_wr_i,
  input wire mgmt_rd_i,
  input wire [15:0] mgmt_wdata_i,
  output wire [15:0] mgmt_rdata_o,
  output wire mgmt_rvalid_o,
  // LED function sources and pins
  input wire led1_func_i,
  input wire led2_func_i,
  output wire led1_o,
  output wire led2_o,
  // Wake packet detection
  input wire wake_match_i,
  input wire wake_crc_bad_i,
  output wire wake_ind_o,
  output wire wake_event_o
);

  // Strap synchronisers
  reg [6:0] strap_meta_ff;
  reg [6:0] strap_sync_ff;
  wire [6:0] strap_pins;

  // Strap latch control
  reg [1:0] settle_cnt_ff;
  reg strap_done_ff;
  wire strap_load;

  // Latched straps
  reg addr1_ff;
  reg addr0_ff;
  reg xover_ff;
  reg rmii_role_ff;
  reg autoneg_ff;
  reg link_pol_ff;

  // Writable registers
  reg [15:0] led_ctrl_ff;
  reg [15:0] nxt_led_ctrl;
  reg [15:0] wake_cfg_ff;
  reg [15:0] nxt_wake_cfg;

  // Read path
  reg [15:0] rdata_ff;
  reg [15:0] nxt_rdata;
  reg rvalid_ff;
  wire [15:0] strap_one_val;
  wire [15:0] strap_two_val;

  // LED path
  reg led1_ff;
  reg led2_ff;
  wire led1_on;
  wire led2_on;

  // Wake path
  reg wake_event_ff;
  reg wake_clr_ff;
  wire wake_hit;
  wire wr_led;
  wire wr_wake;

  // Reset images, so single bits can be picked from them
  localparam [15:0] RST_ONE = `SLWCR_RST_STRAP_ONE;
  localparam [15:0] RST_TWO = `SLWCR_RST_STRAP_TWO;

  assign strap_pins = {strap_led1_polarity_i, strap_link_lamp_polarity_i,
                       strap_autoneg_i, strap_rmii_role_i, strap_auto_crossover_i,
                       strap_addr_bit0_i, strap_addr_bit1_i};

  // Two-stage synchroniser per strap pin
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_strap_sync
      always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          strap_meta_ff[gi] <= 1'b0;
          strap_sync_ff[gi] <= 1'b0;
        end else begin
          strap_meta_ff[gi] <= strap_pins[gi];
          strap_sync_ff[gi] <= strap_meta_ff[gi];
        end
      end
    end
  endgenerate

  // Latch straps once, after synchronisers have settled
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else begin
      if (settle_cnt_ff != `SLWCR_STRAP_SETTLE) begin
        settle_cnt_ff <= settle_cnt_ff + 2'h1;
      end
      if (strap_load) begin
        strap_done_ff <= 1'b1;
      end
    end
  end

  assign strap_load = (settle_cnt_ff == `SLWCR_STRAP_SETTLE) && !strap_done_ff;

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr1_ff <= RST_ONE[`SLWCR_B_ADDR1];
      addr0_ff <= RST_ONE[`SLWCR_B_ADDR0];
      xover_ff <= RST_ONE[`SLWCR_B_XOVER];
      rmii_role_ff <= RST_ONE[`SLWCR_B_RMII_ROLE];
      autoneg_ff <= RST_ONE[`SLWCR_B_AUTONEG];
      link_pol_ff <= RST_TWO[`SLWCR_B_LINK_POL];
    end else if (strap_load) begin
      addr1_ff <= strap_sync_ff[0]; // [RULE1]
      addr0_ff <= strap_sync_ff[1]; // [RULE1]
      xover_ff <= strap_sync_ff[2]; // [RULE2]
      rmii_role_ff <= strap_sync_ff[3]; // [RULE3]
      autoneg_ff <= strap_sync_ff[4]; // [RULE4]
      link_pol_ff <= strap_sync_ff[5]; // [RULE5]
    end
  end

  // Read-only strap images, reserved bits zero
  assign strap_one_val = {2'b00, addr1_ff, addr0_ff, 3'b000, xover_ff, // [RULE1] [RULE2]
                          4'h0, rmii_role_ff, 2'b00, autoneg_ff}; // [RULE3] [RULE4]
  assign strap_two_val = {8'h00, link_pol_ff, 7'h00}; // [RULE5] [RULE12]

  assign wr_led = mgmt_wr_i && (mgmt_addr_i == `SLWCR_OFS_LED_CTRL);
  assign wr_wake = mgmt_wr_i && (mgmt_addr_i == `SLWCR_OFS_WAKE_CFG);

  // LED control register
  always @* begin
    nxt_led_ctrl = led_ctrl_ff;
    if (wr_led) begin
      nxt_led_ctrl = mgmt_wdata_i & `SLWCR_MASK_LED_CTRL; // [RULE6] [RULE12]
    end else if (strap_load) begin
      nxt_led_ctrl[`SLWCR_B_LED1_POL] = strap_sync_ff[6]; // [RULE7]
    end
  end

  // Wake filter config register, clear bit never stored
  always @* begin
    nxt_wake_cfg = wake_cfg_ff;
    if (wr_wake) begin
      nxt_wake_cfg = mgmt_wdata_i & `SLWCR_MASK_WAKE_CFG; // [RULE12] [RULE10]
    end
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_ctrl_ff <= `SLWCR_RST_LED_CTRL;
      wake_cfg_ff <= `SLWCR_RST_WAKE_CFG;
      wake_clr_ff <= 1'b0;
    end else begin
      led_ctrl_ff <= nxt_led_ctrl;
      wake_cfg_ff <= nxt_wake_cfg;
      wake_clr_ff <= wr_wake && mgmt_wdata_i[`SLWCR_B_WAKE_CLR]; // [RULE10]
    end
  end

  // Read decode
  always @* begin
    case (mgmt_addr_i)
      `SLWCR_OFS_IO_CONTROL: nxt_rdata = `SLWCR_RST_IO_CONTROL; // [RULE12]
      `SLWCR_OFS_STRAP_ONE: nxt_rdata = strap_one_val;
      `SLWCR_OFS_STRAP_TWO: nxt_rdata = strap_two_val;
      `SLWCR_OFS_LED_CTRL: nxt_rdata = led_ctrl_ff;
      `SLWCR_OFS_WAKE_CFG: nxt_rdata = wake_cfg_ff; // [RULE10]
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= mgmt_rd_i;
      if (mgmt_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // LED drive: override value or normal function, then polarity
  assign led1_on = led_ctrl_ff[`SLWCR_B_LED1_EN] ?
                   led_ctrl_ff[`SLWCR_B_LED1_VAL] : led1_func_i; // [RULE8]
  assign led2_on = led_ctrl_ff[`SLWCR_B_LED2_EN] ?
                   led_ctrl_ff[`SLWCR_B_LED2_VAL] : led2_func_i; // [RULE8]

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led1_ff <= 1'b1;
      led2_ff <= 1'b0;
    end else begin
      led1_ff <= led_ctrl_ff[`SLWCR_B_LED1_POL] ? led1_on : ~led1_on; // [RULE7]
      led2_ff <= led_ctrl_ff[`SLWCR_B_LED2_POL] ? led2_on : ~led2_on; // [RULE6]
    end
  end

  // Wake event qualification with bad-CRC gating
  assign wake_hit = wake_match_i && wake_cfg_ff[`SLWCR_B_WAKE_EN] &&
                    !(wake_crc_bad_i && wake_cfg_ff[`SLWCR_B_CRC_GATE]); // [RULE9]

  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_event_ff <= 1'b0;
    end else begin
      wake_event_ff <= wake_hit; // [RULE9]
    end
  end

  slwcr_wake_ind u_wake_ind (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .event_i(wake_event_ff),
    .style_i(wake_cfg_ff[`SLWCR_B_WAKE_STYLE]), // [RULE11]
    .width_sel_i(wake_cfg_ff[`SLWCR_B_PULSE_HI:`SLWCR_B_PULSE_LO]),
    .clear_i(wake_clr_ff), // [RULE10]
    .ind_o(wake_ind_o)
  );

  assign mgmt_rdata_o = rdata_ff;
  assign mgmt_rvalid_o = rvalid_ff;
  assign led1_o = led1_ff;
  assign led2_o = led2_ff;
  assign wake_event_o = wake_event_ff;

endmodule // slwcr_top

`default_nettype wire

// [tb/slwcr_props.sv]
`default_nettype none
module slwcr_props (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [10:0] mgmt_addr_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic mgmt_rvalid_o,
  // Pins
  input wire logic led1_o,
  input wire logic led2_o,
  input wire logic wake_match_i,
  input wire logic wake_ind_o,
  input wire logic wake_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd(a);
    mgmt_rd_i && mgmt_addr_i == a;
  endsequence
  sequence s_force(b);
    mgmt_wr_i && mgmt_addr_i == 11'h469 && mgmt_wdata_i[b] ##1 !mgmt_wr_i;
  endsequence
  a_read_answer: assert property (mgmt_rd_i |=> mgmt_rvalid_o)
    else $error("read not answered");
  a_io_zero: assert property (s_rd(11'h461) |=> mgmt_rdata_o == 16'h0000)
    else $error("io control not zero");
  a_one_reserved: assert property (s_rd(11'h467) |=> (mgmt_rdata_o & 16'hCEF6) == 16'h0000)
    else $error("strap one reserved bits set");
  a_two_reserved: assert property (s_rd(11'h468) |=> (mgmt_rdata_o & 16'hFF7F) == 16'h0000)
    else $error("strap two reserved bits set");
  a_led_reserved: assert property (s_rd(11'h469) |=> (mgmt_rdata_o & 16'hFF88) == 16'h0000)
    else $error("led control reserved bits set");
  a_clr_reads_zero: assert property (s_rd(11'h4A0) |=> !mgmt_rdata_o[11])
    else $error("clear bit reads one");
  a_led1_force: assert property (s_force(0) |=>
    led1_o == ($past(mgmt_wdata_i[1], 2) ~^ $past(mgmt_wdata_i[2], 2)))
    else $error("led1 override wrong");
  a_led2_force: assert property (s_force(4) |=>
    led2_o == ($past(mgmt_wdata_i[5], 2) ~^ $past(mgmt_wdata_i[6], 2)))
    else $error("led2 override wrong");
  a_event_cause: assert property (wake_event_o |-> $past(wake_match_i))
    else $error("event without match");
  a_ind_cause: assert property ($rose(wake_ind_o) |-> $past(wake_event_o))
    else $error("indication without event");
  c_event: cover property (wake_event_o);
  c_read: cover property (mgmt_rvalid_o);
  c_ind_end: cover property ($fell(wake_ind_o));
endmodule // slwcr_props
bind slwcr_top slwcr_props u_props (.sys_clk_i, .rstn_i, .mgmt_addr_i, .mgmt_wr_i, .mgmt_rd_i,
  .mgmt_wdata_i, .mgmt_rdata_o, .mgmt_rvalid_o, .led1_o, .led2_o, .wake_match_i, .wake_ind_o,
  .wake_event_o);
`default_nettype wire

// [tb/slwcr_mgmt_model.sv]
`default_nettype none
module slwcr_mgmt_model (
  // Clock
  input wire logic sys_clk_i,
  // Register port
  output logic [10:0] mgmt_addr_o,
  output logic mgmt_wr_o,
  output logic mgmt_rd_o,
  output logic [15:0] mgmt_wdata_o,
  input wire logic [15:0] mgmt_rdata_i,
  input wire logic mgmt_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mgmt_addr_o = 11'h000;
    mgmt_wr_o = 1'b0;
    mgmt_rd_o = 1'b0;
    mgmt_wdata_o = 16'h0000;
  end
  // Single write; bit 11 of wake config clears the held level
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    mgmt_addr_o = a;
    mgmt_wdata_o = d;
    mgmt_wr_o = 1'b1;
    @(negedge sys_clk_i);
    mgmt_wr_o = 1'b0;
    mgmt_wdata_o = ~d;
  endtask
  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(negedge sys_clk_i);
    mgmt_addr_o = a;
    mgmt_rd_o = 1'b1;
    @(negedge sys_clk_i);
    mgmt_rd_o = 1'b0;
    d = mgmt_rvalid_i ? mgmt_rdata_i : 16'hxxxx;
  endtask
endmodule // slwcr_mgmt_model
`default_nettype wire

// [tb/slwcr_top_tb.sv]
`default_nettype none
module slwcr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, wr, rd, rvalid, f1, f2, l1, l2, match, crc_bad, ind, evt;
  logic [6:0] strap;
  logic [10:0] addr;
  logic [15:0] wdata, rdata;
  int errors, total_checks;
  slwcr_top uut (.sys_clk_i(sys_clk), .rstn_i(rstn), .strap_addr_bit1_i(strap[6]),
    .strap_addr_bit0_i(strap[5]), .strap_auto_crossover_i(strap[4]),
    .strap_rmii_role_i(strap[3]), .strap_autoneg_i(strap[2]),
    .strap_link_lamp_polarity_i(strap[1]), .strap_led1_polarity_i(strap[0]),
    .mgmt_addr_i(addr), .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_wdata_i(wdata),
    .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .led1_func_i(f1), .led2_func_i(f2),
    .led1_o(l1), .led2_o(l2), .wake_match_i(match), .wake_crc_bad_i(crc_bad),
    .wake_ind_o(ind), .wake_event_o(evt));
  slwcr_mgmt_model mgmt (.sys_clk_i(sys_clk), .mgmt_addr_o(addr), .mgmt_wr_o(wr),
    .mgmt_rd_o(rd), .mgmt_wdata_o(wdata), .mgmt_rdata_i(rdata), .mgmt_rvalid_i(rvalid));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset with straps, reset values, latched values, ignored writes
  task automatic t_straps(input logic [6:0] s, input logic [10:0] a2, input logic [15:0] e2);
    logic [15:0] v;
    rstn = 1'b0;
    strap = s;
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    mgmt.rd(11'h469, v); chk(v, 16'h0040);
    mgmt.rd(a2, v); chk(v, e2);
    @(negedge sys_clk);
    mgmt.rd(11'h467, v); chk(v, {2'b00, s[6:5], 3'b000, s[4], 4'h0, s[3], 2'b00, s[2]});
    mgmt.rd(11'h468, v); chk(v, {8'h00, s[1], 7'h00});
    mgmt.rd(11'h469, v); chk(v, {9'h000, 1'b1, 3'b000, s[0], 2'b00});
    mgmt.wr(11'h461, 16'hFFFF);
    mgmt.wr(11'h467, 16'hFFFF);
    mgmt.wr(11'h468, 16'hFFFF);
    mgmt.wr(11'h469, 16'hFFFF);
    mgmt.wr(11'h4A0, 16'hFFFF);
    mgmt.rd(11'h461, v); chk(v, 16'h0000);
    mgmt.rd(11'h470, v); chk(v, 16'h0000);
    mgmt.rd(11'h468, v); chk(v, {8'h00, s[1], 7'h00});
    mgmt.rd(11'h469, v); chk(v, 16'h0077);
    mgmt.rd(11'h4A0, v); chk(v, 16'h17E1);
    $display("test straps done");
  endtask
  // Normal function and forced drive through polarity, both lamps
  task automatic t_led;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      f1 = c[3];
      f2 = ~c[3];
      mgmt.wr(11'h469, {9'h000, c[2:0], 1'b0, c[2:0]});
      @(negedge sys_clk);
      chk({15'h0000, l1}, {15'h0000, (c[0] ? c[1] : c[3]) ~^ c[2]});
      chk({15'h0000, l2}, {15'h0000, (c[0] ? c[1] : ~c[3]) ~^ c[2]});
    end
    $display("test led done");
  endtask
  // One match, then count indication and event cycles
  task automatic t_wake(input logic [15:0] cfg, input logic bad, input int ni, input int ne);
    int ci, ce;
    ci = 0;
    ce = 0;
    mgmt.wr(11'h4A0, cfg);
    match = 1'b1;
    crc_bad = bad;
    @(negedge sys_clk);
    match = 1'b0;
    crc_bad = ~bad;
    repeat (80) begin
      if (ind === 1'b1) ci++;
      if (evt === 1'b1) ce++;
      @(negedge sys_clk);
    end
    chk(ci[15:0], ni[15:0]);
    chk(ce[15:0], ne[15:0]);
    $display("test wake done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
  initial begin
    logic [15:0] v;
    rstn = 1'b0;
    strap = 7'h00;
    match = 1'b0;
    crc_bad = 1'b0;
    f1 = 1'b0;
    f2 = 1'b0;
    t_straps(7'b1011010, 11'h467, 16'h0101);
    t_straps(7'b0100101, 11'h468, 16'h0080);
    t_led();
    t_wake(16'h1081, 1'b1, 0, 0);
    t_wake(16'h0081, 1'b1, 8, 1);
    t_wake(16'h1001, 1'b0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      t_wake(16'h1081 | (16'h0200 * k), 1'b0, 8 << k, 1);
    end
    t_wake(16'h1181, 1'b0, 79, 1);
    mgmt.wr(11'h4A0, 16'h1981);
    repeat (2) @(negedge sys_clk);
    chk({15'h0000, ind}, 16'h0000);
    mgmt.rd(11'h4A0, v); chk(v, 16'h1181);
    $display("test level clear done");
    stop_test();
  end
endmodule // slwcr_top_tb
`default_nettype wire
